// ==== tb/flash_status_write_and_id_read_tb.sv ====
`default_nettype none
module flash_status_write_and_id_read_tb
   import flash_cmd_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // identity values, all arbitrary
   localparam byte_t      MFR = 8'h5A;
   localparam logic [2:0] FAM = 3'h5;
   localparam logic [4:0] DEN = 5'h11;
   localparam logic [2:0] SUB = 3'h6;
   localparam logic [4:0] VER = 5'h09;
   localparam byte_t      LEG = 8'hC3;

   typedef struct packed {
      logic [1:0] mode;  // 0 none, 1 write enable, 2 volatile enable
      logic       two;
      byte_t      b1;
      byte_t      b2;
      logic       wp;
      byte_t      lo;
      byte_t      hi;
   } row_t;

   logic        clock;
   logic        arst_n;
   logic        wp_n;
   logic        cs_n;
   logic        sck;
   logic        si;
   logic        so_out;
   logic        so_oe;
   logic        quad_io_mode;
   byte_t       status_low;
   byte_t       status_high;
   wire         so_line;
   int          fail_count;
   int          tests_run;
   logic [63:0] rx;

   // status writes run in order, each row building on the state left by the last
   row_t rows [9] = '{
      '{2'h1, 1'b1, 8'h7F, 8'hFE, 1'b1, 8'h7C, 8'h7A},
      '{2'h1, 1'b0, 8'hA7, 8'h00, 1'b1, 8'hA4, 8'h7A},
      '{2'h2, 1'b1, 8'h08, 8'h00, 1'b1, 8'h08, 8'h00},
      '{2'h0, 1'b0, 8'hF0, 8'h00, 1'b1, 8'h08, 8'h00},
      '{2'h1, 1'b0, 8'h84, 8'h00, 1'b0, 8'h84, 8'h00},
      '{2'h1, 1'b0, 8'h00, 8'h00, 1'b0, 8'h84, 8'h00},
      '{2'h2, 1'b0, 8'h00, 8'h00, 1'b1, 8'h00, 8'h00},
      '{2'h2, 1'b1, 8'h00, 8'h01, 1'b1, 8'h00, 8'h01},
      '{2'h1, 1'b0, 8'hFC, 8'h00, 1'b1, 8'h00, 8'h01}
   };

   ////////////////////////////////////////////////////////////////////////////////
   // released line floats: nothing pulls it
   assign so_line = so_oe ? so_out : 1'bz;

   always #4 clock = ~clock;

   flash_status_id #(
      .MFR_CODE     (MFR),
      .FAMILY_CODE  (FAM),
      .DENSITY_CODE (DEN),
      .SUB_CODE     (SUB),
      .VERSION_CODE (VER),
      .LEGACY_CODE  (LEG)
   ) flash_status_id_i (
      .clock        (clock),
      .arst_n       (arst_n),
      .cs_n         (cs_n),
      .sck          (sck),
      .si           (si),
      .wp_n         (wp_n),
      .so_out       (so_out),
      .so_oe        (so_oe),
      .status_low   (status_low),
      .status_high  (status_high),
      .quad_io_mode (quad_io_mode)
   );

   host_spi_model host_spi_model_i (
      .clock   (clock),
      .cs_n    (cs_n),
      .sck     (sck),
      .si      (si),
      .so_line (so_line)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic op(input int n, input logic [63:0] tx);
      host_spi_model_i.frame(n, tx, rx);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a full run is near 80 us; five times that means a hang
   initial begin
      #400_000;
      fail_count++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock      = 1'b0;
      arst_n     = 1'b0;
      wp_n       = 1'b1;
      fail_count = 0;
      tests_run  = 0;
      repeat (8) @(posedge clock);
      #1;
      arst_n = 1'b1;
      repeat (6) @(posedge clock);
      #1;
      check(status_low, 8'h00);
      // table of status writes
      for (int k = 0; k < 9; k++) begin
         wp_n = rows[k].wp;
         if (rows[k].mode == 2'h1) op(8, 64'h06);
         if (rows[k].mode == 2'h2) op(8, 64'h50);
         if (rows[k].two) op(24, {40'h0, 8'h01, rows[k].b1, rows[k].b2});
         else op(16, {48'h0, 8'h01, rows[k].b1});
         check(status_low, rows[k].lo);
         check(status_high, rows[k].hi);
         check(quad_io_mode, rows[k].hi[1]);
      end
      // second reset: the stored image resets to zero and the working copy reloads from it
      arst_n = 1'b0;
      repeat (8) @(posedge clock);
      #1;
      arst_n = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      check({status_low, status_high}, 16'h0000);
      // misaligned release, then opcode-only frame: nothing changes, latch drops
      op(8, 64'h06);
      check(status_low, 8'h02);
      op(20, {44'h0, 8'h01, 8'h30, 4'h0});
      check(status_low, 8'h00);
      op(8, 64'h06);
      op(8, 64'h01);
      check(status_low, 8'h00);
      // volatile enable covers one write only and leaves the latch alone
      op(8, 64'h50);
      check(status_low, 8'h00);
      op(16, {48'h0, 16'h01A4});
      check(status_low, 8'hA4);
      op(16, {48'h0, 16'h01F0});
      check({status_low, status_high}, 16'hA400);
      // identification reads
      op(32, {32'h0, 32'h9F00_0000});
      check(rx[23:0], {MFR, FAM, DEN, SUB, VER});
      check(so_oe, 1'b0);
      op(64, {8'h90, 56'h0});
      check(rx[31:0], {MFR, LEG, MFR, LEG});
      op(48, {16'h0, 8'hAB, 40'h0});
      check(rx[15:0], {LEG, LEG});
      // release in mid-byte of the readout
      op(12, {52'h0, 12'h9F0});
      check(so_oe, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire

// ==== tb/host_spi_model.sv ====
`default_nettype none
module host_spi_model (
   // clock
   input  wire logic clock,
   // serial link
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // 80 ns a half, 160 ns a period: slow enough for identification
   localparam int HALF = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // idle: deselected, clock parked low (mode 0)
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end

   // every pin change lands just after a system clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // one frame: bits msb first, set while sck low, sampled back on the rise
   // the bench chooses opcode order and enables before writes
   task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
      rx   = '0;
      tick(1);
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si  = tx[i];
         tick(HALF);
         sck = 1'b1;
         rx  = {rx[62:0], so_line};
         tick(HALF);
         sck = 1'b0;
      end
      tick(5);
      cs_n = 1'b1;
      // hold time is over: show the inverse, never a stale bit that could pass by luck
      si   = ~si;
      tick(8);
   endtask
endmodule
`default_nettype wire

// ==== verilog/flash_cmd_defs.svh ====
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// opcodes
`define OP_WRITE_STATUS  8'h01
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_ENABLE  8'h06
`define OP_VOL_ENABLE    8'h50
`define OP_READ_ID       8'h9F
`define OP_LEGACY_ID     8'h90
`define OP_RESUME_ID     8'hAB

// byte counts, opcode included
`define ID_LEAD_BYTES    3'h4
`define WR_ONE_BYTE      3'h2
`define WR_TWO_BYTES     3'h3

// field positions
`define LOW_PROT_LO_BIT  7
`define HIGH_QE_BIT      1
`define HIGH_PROT_HI_BIT 0

// write masks and reset values
`define LOW_WR_MASK      8'hFC
`define HIGH_WR_MASK     8'h7B
`define NV_LOW_RST       8'h00
`define NV_HIGH_RST      8'h00

`endif

// ==== verilog/flash_cmd_pkg.sv ====
`default_nettype none
package flash_cmd_pkg;
   typedef logic [7:0] byte_t;
   // frame progress, gray coded along idle -> opcode -> body
   typedef enum logic [1:0] {
      PH_IDLE   = 2'b00,
      PH_OPCODE = 2'b01,
      PH_BODY   = 2'b11
   } frame_phase_t;
endpackage
`default_nettype wire

// ==== verilog/flash_status_id.sv ====
`default_nettype none
`include "flash_cmd_defs.svh"
module flash_status_id
   import flash_cmd_pkg::*;
#(
   parameter byte_t      MFR_CODE     = 8'hA5,  // arbitrary value
   parameter logic [2:0] FAMILY_CODE  = 3'h2,   // arbitrary value
   parameter logic [4:0] DENSITY_CODE = 5'h0C,  // arbitrary value
   parameter logic [2:0] SUB_CODE     = 3'h1,   // arbitrary value
   parameter logic [4:0] VERSION_CODE = 5'h03,  // arbitrary value
   parameter byte_t      LEGACY_CODE  = 8'h3C   // arbitrary value
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // serial link pins
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic wp_n,
   output logic      so_out,
   output logic      so_oe,
   // status view
   output byte_t     status_low,
   output byte_t     status_high,
   output logic      quad_io_mode
);
   ////////////////////////////////////////////////////////////////////////////
   // elaboration check: all ones would look like an undriven bus
   if (MFR_CODE == 8'hFF) begin : g_bad_mfr
      $error("maker code must not be all ones");
   end

   logic         cs_n_s, si_s, wp_n_s, sck_rise, sck_fall, cs_rise;
   logic [2:0]   bit_cnt_reg;
   logic [2:0]   byte_cnt_reg;
   logic         par_reg;
   byte_t        shift_reg, opcode_reg, data1_reg, data2_reg;
   frame_phase_t phase_reg;
   byte_t        nv_low_reg, nv_high_reg, vol_low_reg, vol_high_reg;
   logic         wel_reg, vol_en_reg, load_reg;
   logic         wr_end, wr_complete, wr_ok;
   logic [1:0]   id_now;

   spi_pin_sync u_sync (
      .clock    (clock),
      .arst_n   (arst_n),
      .cs_n_pin (cs_n),
      .sck_pin  (sck),
      .si_pin   (si),
      .wp_n_pin (wp_n),
      .cs_n_s   (cs_n_s),
      .si_s     (si_s),
      .wp_n_s   (wp_n_s),
      .sck_rise (sck_rise),
      .sck_fall (sck_fall),
      .cs_rise  (cs_rise)
   );

   // refused when protect pair locks the register
   function automatic logic locked(input logic hi, input logic lo, input logic wp);
      locked = (hi | lo) & ~(~hi & lo & wp);
   endfunction

   // id bit for the current position, with its valid flag; valid only during an id phase
   function automatic logic [1:0] id_bit(input byte_t op, input logic [2:0] bc,
                                         input logic par, input logic [2:0] bi);
      byte_t b;
      logic  v;
      b = 8'h00;
      v = 1'b0;
      case (op)
         `OP_READ_ID: begin
            v = (bc != 3'h0);
            case (bc)
               3'h1:    b = MFR_CODE;
               3'h2:    b = {FAMILY_CODE, DENSITY_CODE};
               3'h3:    b = {SUB_CODE, VERSION_CODE};
               default: b = 8'h00;
            endcase
         end
         `OP_LEGACY_ID: begin
            v = (bc >= `ID_LEAD_BYTES);
            b = par ? LEGACY_CODE : MFR_CODE;
         end
         `OP_RESUME_ID: begin
            v = (bc >= `ID_LEAD_BYTES);
            b = LEGACY_CODE;
         end
         default: begin
            v = 1'b0;
            b = 8'h00;
         end
      endcase
      id_bit = {v, b[~bi]};  // msb first
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // shift-in on rising serial clock; counters cleared while deselected
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
         par_reg      <= 1'b0;
         shift_reg    <= 8'h00;
         opcode_reg   <= 8'h00;
         data1_reg    <= 8'h00;
         data2_reg    <= 8'h00;
         phase_reg    <= PH_IDLE;
      end else if (cs_n_s) begin
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
         par_reg      <= 1'b0;
         phase_reg    <= PH_IDLE;
      end else if (sck_rise) begin
         shift_reg   <= {shift_reg[6:0], si_s};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (phase_reg == PH_IDLE) begin
            phase_reg <= PH_OPCODE;
         end
         if (bit_cnt_reg == 3'h7) begin
            par_reg <= ~par_reg;
            // saturate at 7; the legacy readout only needs to know it is past the 4-byte lead-in
            if (byte_cnt_reg != 3'h7) begin
               byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
            case (byte_cnt_reg)
               3'h0: begin
                  opcode_reg <= {shift_reg[6:0], si_s};
                  phase_reg  <= PH_BODY;
               end
               3'h1:    data1_reg <= {shift_reg[6:0], si_s};
               3'h2:    data2_reg <= {shift_reg[6:0], si_s};
               default: data2_reg <= data2_reg;
            endcase
         end
      end
   end

   // frame-end decode of a status write
   assign wr_end      = cs_rise && (byte_cnt_reg != 3'h0) && (opcode_reg == `OP_WRITE_STATUS);
   assign wr_complete = (bit_cnt_reg == 3'h0) && (byte_cnt_reg >= `WR_ONE_BYTE);
   assign wr_ok       = wr_end && wr_complete && (wel_reg || vol_en_reg)
                        && !locked(vol_high_reg[`HIGH_PROT_HI_BIT], vol_low_reg[`LOW_PROT_LO_BIT], wp_n_s);

   ////////////////////////////////////////////////////////////////////////////
   // write enable latch and one-shot volatile enable
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wel_reg    <= 1'b0;
         vol_en_reg <= 1'b0;
      end else if (cs_rise && byte_cnt_reg != 3'h0) begin
         if (wr_end) begin
            wel_reg <= 1'b0;  // success or abort alike
         end else if (bit_cnt_reg == 3'h0 && opcode_reg == `OP_WRITE_ENABLE) begin
            wel_reg <= 1'b1;
         end else if (bit_cnt_reg == 3'h0 && opcode_reg == `OP_WRITE_DISABLE) begin
            wel_reg <= 1'b0;
         end
         // armed by its own opcode, spent by the next command
         vol_en_reg <= (opcode_reg == `OP_VOL_ENABLE) && (bit_cnt_reg == 3'h0);
      end
   end

   // one-cycle load flag after reset release
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         load_reg <= 1'b1;
      end else begin
         load_reg <= 1'b0;
      end
   end

   // status storage; only writable bits are touched
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         nv_low_reg   <= `NV_LOW_RST;
         nv_high_reg  <= `NV_HIGH_RST;
         vol_low_reg  <= 8'h00;
         vol_high_reg <= 8'h00;
      end else if (load_reg) begin
         vol_low_reg  <= nv_low_reg;
         vol_high_reg <= nv_high_reg;
      end else if (wr_ok) begin
         vol_low_reg <= (vol_low_reg & ~`LOW_WR_MASK) | (data1_reg & `LOW_WR_MASK);
         if (byte_cnt_reg >= `WR_TWO_BYTES) begin
            vol_high_reg <= (vol_high_reg & ~`HIGH_WR_MASK) | (data2_reg & `HIGH_WR_MASK);
         end
         // a volatile-only write leaves the stored image alone
         if (!vol_en_reg) begin
            nv_low_reg <= (nv_low_reg & ~`LOW_WR_MASK) | (data1_reg & `LOW_WR_MASK);
            if (byte_cnt_reg >= `WR_TWO_BYTES) begin
               nv_high_reg <= (nv_high_reg & ~`HIGH_WR_MASK) | (data2_reg & `HIGH_WR_MASK);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // {drive, bit} for the position the next falling edge presents
   assign id_now = id_bit(opcode_reg, byte_cnt_reg, par_reg, bit_cnt_reg);

   // serial output changes on falling serial clock
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         so_out <= 1'b0;
         so_oe  <= 1'b0;
      end else if (cs_n_s) begin
         so_out <= 1'b0;
         so_oe  <= 1'b0;
      end else if (sck_fall) begin
         so_oe  <= id_now[1];
         so_out <= id_now[0];
      end
   end

   // status view; busy stays clear as no self-timed work lives here
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         status_low   <= 8'h00;
         status_high  <= 8'h00;
         quad_io_mode <= 1'b0;
      end else begin
         status_low   <= {vol_low_reg[7:2], wel_reg, 1'b0};
         status_high  <= vol_high_reg & `HIGH_WR_MASK;
         quad_io_mode <= vol_high_reg[`HIGH_QE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_wr_end;
      wr_end;
   endsequence

   sequence s_wr_abort;
      wr_end && !wr_complete;
   endsequence

   property p_wel_clear;
      @(posedge clock) disable iff (!arst_n) s_wr_end |=> !wel_reg;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared after status write");

   property p_abort_stable;
      @(posedge clock) disable iff (!arst_n)
         s_wr_abort |=> $stable(vol_low_reg) && $stable(vol_high_reg) && !wel_reg;
   endproperty
   a_abort_stable: assert property (p_abort_stable) else $error("aborted write changed status");

   property p_needs_wel;
      @(posedge clock) disable iff (!arst_n)
         s_wr_end ##0 (!$past(wel_reg) && !vol_en_reg && !wel_reg) |=> $stable(nv_low_reg);
   endproperty
   a_needs_wel: assert property (p_needs_wel) else $error("write without latch took effect");

   property p_update;
      @(posedge clock) disable iff (!arst_n)
         wr_ok |=> vol_low_reg[7:2] == $past(data1_reg[7:2]) ##1 status_low[7:2] == $past(data1_reg[7:2], 2);
   endproperty
   a_update: assert property (p_update) else $error("status byte not updated");

   property p_vol_no_wel;
      @(posedge clock) disable iff (!arst_n)
         cs_rise && byte_cnt_reg != 3'h0 && opcode_reg == `OP_VOL_ENABLE && !wel_reg |=> !wel_reg;
   endproperty
   a_vol_no_wel: assert property (p_vol_no_wel) else $error("volatile enable set the latch");

   property p_vol_one_shot;
      @(posedge clock) disable iff (!arst_n) s_wr_end |=> !vol_en_reg;
   endproperty
   a_vol_one_shot: assert property (p_vol_one_shot) else $error("volatile enable outlived a write");

   property p_so_float;
      @(posedge clock) disable iff (!arst_n) cs_n_s |=> !so_oe ##1 !so_oe;
   endproperty
   a_so_float: assert property (p_so_float) else $error("output driven while deselected");

   property p_locked;
      @(posedge clock) disable iff (!arst_n)
         s_wr_end ##0 (vol_high_reg[`HIGH_PROT_HI_BIT] == 1'b1) |=> $stable(vol_low_reg) && $stable(nv_low_reg);
   endproperty
   a_locked: assert property (p_locked) else $error("locked status register was written");

   property p_load;
      @(posedge clock) disable iff (!arst_n) load_reg |=> vol_low_reg == $past(nv_low_reg);
   endproperty
   a_load: assert property (p_load) else $error("working copy not loaded");

   property p_ro_bits;
      @(posedge clock) disable iff (!arst_n) status_low[0] == 1'b0 && status_high[7] == 1'b0;
   endproperty
   a_ro_bits: assert property (p_ro_bits) else $error("read-only bit set");
endmodule
`default_nettype wire

// ==== verilog/spi_pin_sync.sv ====
`default_nettype none
module spi_pin_sync (
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // raw pins
   input  wire logic cs_n_pin,
   input  wire logic sck_pin,
   input  wire logic si_pin,
   input  wire logic wp_n_pin,
   // synchronised levels and events
   output logic      cs_n_s,
   output logic      si_s,
   output logic      wp_n_s,
   output logic      sck_rise,
   output logic      sck_fall,
   output logic      cs_rise
);
   logic [3:0] meta_reg;
   logic [3:0] sync_reg;
   logic       sck_prev_reg;
   logic       cs_prev_reg;

   // two flops per pin; only the second stage is looked at
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 4'h9;
         sync_reg <= 4'h9;
      end else begin
         meta_reg <= {cs_n_pin, sck_pin, si_pin, wp_n_pin};
         sync_reg <= meta_reg;
      end
   end

   // previous values for edge detection
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sck_prev_reg <= 1'b0;
         cs_prev_reg  <= 1'b1;
      end else begin
         sck_prev_reg <= sync_reg[2];
         cs_prev_reg  <= sync_reg[3];
      end
   end

   assign cs_n_s   = sync_reg[3];
   assign si_s     = sync_reg[1];
   assign wp_n_s   = sync_reg[0];
   assign sck_rise = sync_reg[2] & ~sck_prev_reg;
   assign sck_fall = ~sync_reg[2] & sck_prev_reg;
   assign cs_rise  = sync_reg[3] & ~cs_prev_reg;
endmodule
`default_nettype wire
